// File: src/sff_fifo_top.sv
/*
  first-in first-out buffer, 9-bit words, with full, empty and programmable
  almost-full / almost-empty flags and four offset registers.
  assumes push_clock_i and pop_clock_i are slow pins well below clk_i/4; every
  pin is sampled through two flip-flops and pin clock edges become enable pulses.
*/
// Summary of operation
// [RULE1] output enable low drives out_word from output register; high floats it
// [RULE2] load pin high during device reset selects dual write gate mode
// [RULE3] load pin low during device reset selects offset load mode
// [RULE4] dual mode: gate a low and gate b high writes next location per push edge
// [RULE5] dual mode: gate a high or gate b low stores nothing
// [RULE6] full buffer drives full_n low and ignores both write gates
// [RULE7] after a read on full buffer, full_n releases on a push edge
// [RULE8] load mode offers four 8-bit offset registers, written and read through data
// [RULE9] load and gate a low: push edges write the four offsets cyclically
// [RULE10] raising load resumes normal operation and keeps the sequence position
// [RULE11] load and read gates low: pop edges present offsets in the same cycle order
// [RULE12] outside logic never reads and writes offsets in the same period
// [RULE13] full offset low byte resets to seven, high byte to zero
// [RULE14] without reads, full_n goes low after exactly depth writes
// [RULE15] full_n and almost_full_n change only on push edges
// [RULE16] equal pointers drive empty_n low and block reads; updates on pop edges
// [RULE17] almost_full_n low once stored words reach depth minus full offset
// [RULE18] default full offset places almost_full_n at depth minus seven
// [RULE19] almost_empty_n low while stored words are at most empty offset; pop edges
// [RULE20] default empty offset gives almost_empty_n low at seven or fewer words
// [RULE21] read words leave on a 9-bit output bus
// [RULE22] device reset clears pointers, sets flags, clears output, restores offsets
// [RULE23] read gates low and not empty: pop edge loads next word, else output holds
// [RULE24] load mode: gate a alone gates buffer writes
// [RULE25] outside logic resets the device after power-up before writing
// [RULE26] effective offsets join high over low, trimmed to pointer width
// [RULE27] full side reads a pointer copy taken on push edges, empty side on pop edges
`timescale 1ns/1ps
module sff_fifo_top #(
  parameter int DEPTH = 64
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // device reset pin
  input  wire logic       init_n_i,
  // write side pins
  input  wire logic       push_clock_i,
  input  wire logic       write_gate_a_n_i,
  input  wire logic       write_gate_b_or_load_i,
  input  wire logic [8:0] in_word_i,
  // read side pins
  input  wire logic       pop_clock_i,
  input  wire logic       read_gate_a_n_i,
  input  wire logic       read_gate_b_n_i,
  input  wire logic       q_drive_enable_n_i,
  // data out, two signals of a three-state bus
  output logic      [8:0] out_word_o,
  output logic            out_word_oe_o,
  // flags
  output logic            full_n_o,
  output logic            almost_full_n_o,
  output logic            empty_n_o,
  output logic            almost_empty_n_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

  typedef struct packed
  {
    logic [2:0]                push_sy;
    logic [2:0]                pop_sy;
    logic [1:0]                gate_a_sy;
    logic [1:0]                gate_b_sy;
    logic [1:0]                rgate_a_sy;
    logic [1:0]                rgate_b_sy;
    logic [1:0]                init_sy;
    logic [1:0]                oe_sy;
    logic [1:0][8:0]           din_sy;
    sff_pkg::sff_mode_type     mode;
    logic [AW:0]               wcnt;
    logic [AW:0]               mem_wp;
    logic [AW:0]               rp;
    logic [AW:0]               rp_copy;
    logic [AW:0]               wp_copy;
    logic [DEPTH-1:0][8:0]     ram;
    logic [8:0]                out_q;
    logic [3:0][7:0]           ofs;
    logic [1:0]                wsel;
    logic [1:0]                rsel;
    logic                      full_n;
    logic                      afull_n;
    logic                      empty_n;
    logic                      aempty_n;
  } sff_state_type;

  sff_state_type state_reg;
  sff_state_type state_next;

  sff_stream_if #(.WIDTH(sff_pkg::WORD_W)) stage_in ();
  sff_stream_if #(.WIDTH(sff_pkg::WORD_W)) stage_out ();

  // absorbs back-to-back pin writes while the word array takes one per cycle
  sff_stage_fifo #(
    .WIDTH (sff_pkg::WORD_W),
    .DEPTH (sff_pkg::STAGE_DEPTH)
  ) u_stage (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .fill    (stage_in.sink),
    .drain   (stage_out.source)
  );

  logic        push_edge;
  logic        pop_edge;
  logic        in_init;
  logic        load_active;
  logic        wgate_on;
  logic        rgate_on;
  logic        wr_word;
  logic        wr_ofs;
  logic        rd_word;
  logic        rd_ofs;
  logic [15:0] empty_ofs16;
  logic [15:0] full_ofs16;
  logic [AW:0] n_ofs;
  logic [AW:0] m_ofs;

  // edge detectors compare the settled second stage with the third
  assign push_edge   = state_reg.push_sy[1] && !state_reg.push_sy[2];
  assign pop_edge    = state_reg.pop_sy[1] && !state_reg.pop_sy[2];
  assign in_init     = !state_reg.init_sy[1];
  assign load_active = (state_reg.mode == sff_pkg::SFF_MODE_LOAD) && !state_reg.gate_b_sy[1];
  // both modes write words on gate a low with the second pin high
  assign wgate_on    = !state_reg.gate_a_sy[1] && state_reg.gate_b_sy[1]; // [RULE4] [RULE5] [RULE24]
  assign rgate_on    = !state_reg.rgate_a_sy[1] && !state_reg.rgate_b_sy[1];

  assign wr_word = push_edge && !in_init && wgate_on && state_reg.full_n && stage_in.ready; // [RULE6]
  assign wr_ofs  = push_edge && !in_init && load_active && !state_reg.gate_a_sy[1]; // [RULE9]
  assign rd_word = pop_edge && !in_init && !load_active && rgate_on && state_reg.empty_n; // [RULE16] [RULE23]
  assign rd_ofs  = pop_edge && !in_init && load_active && rgate_on; // [RULE11]

  assign empty_ofs16 = {state_reg.ofs[sff_pkg::SEL_EMPTY_HIGH], state_reg.ofs[sff_pkg::SEL_EMPTY_LOW]}; // [RULE26]
  assign full_ofs16  = {state_reg.ofs[sff_pkg::SEL_FULL_HIGH], state_reg.ofs[sff_pkg::SEL_FULL_LOW]}; // [RULE26]
  assign n_ofs       = {1'b0, empty_ofs16[AW-1:0]};
  assign m_ofs       = {1'b0, full_ofs16[AW-1:0]};

  assign stage_in.valid  = wr_word;
  assign stage_in.data   = state_reg.din_sy[1];
  assign stage_out.ready = !in_init;

  always_comb
  begin
    logic [AW:0] wcnt_n;
    logic [AW:0] rp_n;
    logic [AW:0] fcount;
    logic [AW:0] ecount;
    wcnt_n = state_reg.wcnt;
    rp_n   = state_reg.rp;
    fcount = '0;
    ecount = '0;
    state_next = state_reg;

    // pin synchronisers
    state_next.push_sy    = {state_reg.push_sy[1:0], push_clock_i};
    state_next.pop_sy     = {state_reg.pop_sy[1:0], pop_clock_i};
    state_next.gate_a_sy  = {state_reg.gate_a_sy[0], write_gate_a_n_i};
    state_next.gate_b_sy  = {state_reg.gate_b_sy[0], write_gate_b_or_load_i};
    state_next.rgate_a_sy = {state_reg.rgate_a_sy[0], read_gate_a_n_i};
    state_next.rgate_b_sy = {state_reg.rgate_b_sy[0], read_gate_b_n_i};
    state_next.init_sy    = {state_reg.init_sy[0], init_n_i};
    state_next.oe_sy      = {state_reg.oe_sy[0], q_drive_enable_n_i};
    state_next.din_sy     = {state_reg.din_sy[0], in_word_i};

    if (in_init)
    begin
      // strap caught by the clock while the device reset pin is low
      state_next.mode     = state_reg.gate_b_sy[1] ? sff_pkg::SFF_MODE_DUAL : sff_pkg::SFF_MODE_LOAD; // [RULE2] [RULE3]
      state_next.wcnt     = '0; // [RULE22]
      state_next.mem_wp   = '0;
      state_next.rp       = '0;
      state_next.rp_copy  = '0;
      state_next.wp_copy  = '0;
      state_next.out_q    = sff_pkg::OUT_RST;
      state_next.ofs[sff_pkg::SEL_EMPTY_LOW]  = sff_pkg::EMPTY_LOW_RST; // [RULE20]
      state_next.ofs[sff_pkg::SEL_EMPTY_HIGH] = sff_pkg::EMPTY_HIGH_RST;
      state_next.ofs[sff_pkg::SEL_FULL_LOW]   = sff_pkg::FULL_LOW_RST; // [RULE13] [RULE18]
      state_next.ofs[sff_pkg::SEL_FULL_HIGH]  = sff_pkg::FULL_HIGH_RST;
      state_next.wsel     = sff_pkg::SEL_RST;
      state_next.rsel     = sff_pkg::SEL_RST;
      state_next.full_n   = 1'b1;
      state_next.afull_n  = 1'b1;
      state_next.empty_n  = 1'b0;
      state_next.aempty_n = 1'b0;
    end
    else
    begin
      // staged words enter the array one per cycle
      if (stage_out.valid)
      begin
        state_next.ram[state_reg.mem_wp[AW-1:0]] = stage_out.data;
        state_next.mem_wp = state_reg.mem_wp + (AW+1)'(1);
      end

      // offsets: sequence position survives leaving load state
      if (wr_ofs)
      begin
        state_next.ofs[state_reg.wsel] = state_reg.din_sy[1][7:0]; // [RULE8] [RULE10]
        state_next.wsel = state_reg.wsel + 2'h1; // [RULE9]
      end
      if (rd_ofs)
      begin
        state_next.out_q = {1'b0, state_reg.ofs[state_reg.rsel]}; // [RULE8]
        state_next.rsel  = state_reg.rsel + 2'h1; // [RULE11]
      end

      // write side flags, updated on push edges only
      if (push_edge)
      begin
        if (wr_word)
        begin
          wcnt_n = state_reg.wcnt + (AW+1)'(1);
        end
        state_next.wcnt    = wcnt_n;
        state_next.rp_copy = state_reg.rp; // [RULE27]
        fcount = wcnt_n - state_next.rp_copy;
        state_next.full_n  = (fcount != DEPTH_CNT); // [RULE14] [RULE7] [RULE15]
        state_next.afull_n = (fcount < (DEPTH_CNT - m_ofs)); // [RULE17] [RULE15]
      end

      // read side flags, updated on pop edges only
      if (pop_edge)
      begin
        if (rd_word)
        begin
          state_next.out_q = state_reg.ram[state_reg.rp[AW-1:0]]; // [RULE23] [RULE21]
          rp_n = state_reg.rp + (AW+1)'(1);
        end
        state_next.rp       = rp_n;
        state_next.wp_copy  = state_reg.mem_wp; // [RULE27]
        ecount = state_next.wp_copy - rp_n;
        state_next.empty_n  = (ecount != '0); // [RULE16]
        state_next.aempty_n = (ecount > n_ofs); // [RULE19]
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg          <= '0;
      state_reg.init_sy  <= 2'h0;
      state_reg.oe_sy    <= 2'h3;
      state_reg.full_n   <= 1'b1;
      state_reg.afull_n  <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // output enable pin is synchronised too, so the bus turns two cycles late
  assign out_word_o       = state_reg.out_q; // [RULE21]
  assign out_word_oe_o    = !state_reg.oe_sy[1]; // [RULE1]
  assign full_n_o         = state_reg.full_n;
  assign almost_full_n_o  = state_reg.afull_n;
  assign empty_n_o        = state_reg.empty_n;
  assign almost_empty_n_o = state_reg.aempty_n;
endmodule

// File: src/sff_pkg.sv
/*
  constants and types shared by the programmable-flag buffer and its staging queue.
  assumes a single system clock; all device pins are sampled into that clock.
*/
package sff_pkg;

  // word and offset register geometry
  localparam int WORD_W      = 9;
  localparam int OFS_W       = 8;
  localparam int OFS_CNT     = 4;
  localparam int STAGE_DEPTH = 8;

  // offset register sequence positions
  localparam logic [1:0] SEL_EMPTY_LOW  = 2'h0;
  localparam logic [1:0] SEL_EMPTY_HIGH = 2'h1;
  localparam logic [1:0] SEL_FULL_LOW   = 2'h2;
  localparam logic [1:0] SEL_FULL_HIGH  = 2'h3;
  localparam logic [1:0] SEL_RST        = 2'h0;

  // values after device reset
  localparam logic [7:0] EMPTY_LOW_RST  = 8'h07;
  localparam logic [7:0] EMPTY_HIGH_RST = 8'h00;
  localparam logic [7:0] FULL_LOW_RST   = 8'h07;
  localparam logic [7:0] FULL_HIGH_RST  = 8'h00;
  localparam logic [8:0] OUT_RST        = 9'h000;

  // configuration caught from the dual-purpose pin at device reset
  typedef enum logic
  {
    SFF_MODE_LOAD = 1'b0,
    SFF_MODE_DUAL = 1'b1
  } sff_mode_type;

endpackage

// File: src/sff_stream_if.sv
/*
  valid/ready word channel between the buffer core and its staging queue.
  assumes source and sink share one clock.
*/
`timescale 1ns/1ps
interface sff_stream_if #(
  parameter int WIDTH = 9
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source
  (
    output valid,
    output data,
    input  ready
  );

  modport sink
  (
    input  valid,
    input  data,
    output ready
  );
endinterface

// File: src/sff_stage_fifo.sv
/*
  small staging queue of flip-flops with valid/ready on both sides.
  assumes DEPTH is a power of two and one clock for both sides.
*/
`timescale 1ns/1ps
module sff_stage_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // channels
  sff_stream_if.sink   fill,
  sff_stream_if.source drain
);
  localparam int PW = $clog2(DEPTH) + 1;

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
  } sff_stage_state_type;

  sff_stage_state_type state_reg;
  sff_stage_state_type state_next;
  logic                full;
  logic                empty;

  assign empty = (state_reg.wp == state_reg.rp);
  assign full  = (state_reg.wp[PW-2:0] == state_reg.rp[PW-2:0]) && (state_reg.wp[PW-1] != state_reg.rp[PW-1]);

  assign fill.ready  = !full;
  assign drain.valid = !empty;
  assign drain.data  = state_reg.mem[state_reg.rp[PW-2:0]];

  always_comb
  begin
    state_next = state_reg;
    if (fill.valid && !full)
    begin
      state_next.mem[state_reg.wp[PW-2:0]] = fill.data;
      state_next.wp = state_reg.wp + PW'(1);
    end
    if (drain.ready && !empty)
    begin
      state_next.rp = state_reg.rp + PW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end
endmodule

// File: sim/sff_sva.sv
/*
  pin-level checker for the programmable-flag buffer.
  assumes one clock, pin clocks far slower than clk_i.
*/
`timescale 1ns/1ps
module sff_sva #(
  parameter int DEPTH = 64
)
(
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  // pins
  input wire logic       init_n_i,
  input wire logic       push_clock_i,
  input wire logic       pop_clock_i,
  input wire logic       q_drive_enable_n_i,
  // outputs
  input wire logic [8:0] out_word_o,
  input wire logic       out_word_oe_o,
  input wire logic       full_n_o,
  input wire logic       almost_full_n_o,
  input wire logic       empty_n_o,
  input wire logic       almost_empty_n_o
);
  // cycles since a pin clock rise; sync plus register needs about three
  logic       push_d;
  logic       pop_d;
  logic [3:0] w_cnt;
  logic [3:0] r_cnt;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      push_d <= 1'b0;
      pop_d  <= 1'b0;
      w_cnt  <= 4'h0;
      r_cnt  <= 4'h0;
    end
    else
    begin
      push_d <= push_clock_i;
      pop_d  <= pop_clock_i;
      w_cnt  <= ((push_clock_i && !push_d) || !init_n_i) ? 4'h0 : w_cnt + {3'h0, w_cnt != 4'hf};
      r_cnt  <= ((pop_clock_i && !pop_d) || !init_n_i) ? 4'h0 : r_cnt + {3'h0, r_cnt != 4'hf};
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  oe_drive_a: assert property ((!q_drive_enable_n_i) [*5] |-> out_word_oe_o)
    else $error("output not driven");
  oe_float_a: assert property (q_drive_enable_n_i [*5] |-> !out_word_oe_o)
    else $error("output not floated");
  init_flags_a: assert property ((!init_n_i) [*6] |-> full_n_o && almost_full_n_o && !empty_n_o)
    else $error("flags wrong in init");
  init_out_a: assert property ((!init_n_i) [*6] |-> out_word_o == 9'h000 && !almost_empty_n_o)
    else $error("output not cleared in init");
  full_timing_a: assert property ($changed({full_n_o, almost_full_n_o}) |-> w_cnt <= 4'h6)
    else $error("full side moved off push edge");
  empty_timing_a: assert property ($changed({empty_n_o, almost_empty_n_o}) |-> r_cnt <= 4'h6)
    else $error("empty side moved off pop edge");
  out_hold_a: assert property ($changed(out_word_o) |-> r_cnt <= 4'h6)
    else $error("output moved without pop edge");
  full_afull_a: assert property (!full_n_o |-> !almost_full_n_o)
    else $error("full without almost full");
  empty_aempty_a: assert property (!empty_n_o |-> !almost_empty_n_o)
    else $error("empty without almost empty");

  cover property ($fell(full_n_o));
  cover property ($rose(empty_n_o));
  cover property ($rose(out_word_oe_o));
endmodule

bind sff_fifo_top sff_sva #(.DEPTH(DEPTH)) sff_sva_inst
(
  .clk_i(clk_i), .rst_b_i(rst_b_i), .init_n_i(init_n_i),
  .push_clock_i(push_clock_i), .pop_clock_i(pop_clock_i),
  .q_drive_enable_n_i(q_drive_enable_n_i), .out_word_o(out_word_o),
  .out_word_oe_o(out_word_oe_o), .full_n_o(full_n_o), .almost_full_n_o(almost_full_n_o),
  .empty_n_o(empty_n_o), .almost_empty_n_o(almost_empty_n_o)
);

// File: sim/sff_pin_model.sv
/*
  writer and reader logic on the pin side of the buffer.
  assumes the bench calls one task at a time.
*/
`timescale 1ns/1ps
module sff_pin_model
(
  // clock and pacing
  input  wire logic       clk_i,
  input  wire logic [1:0] slow_i,
  // write side
  output logic            push_o,
  output logic            ga_n_o,
  output logic            gb_o,
  output logic      [8:0] word_o,
  // read side
  output logic            pop_o,
  output logic            ra_n_o,
  output logic            rb_n_o,
  output logic            done_o
);
  initial
  begin
    push_o = 1'b0;
    pop_o  = 1'b0;
    ga_n_o = 1'b1;
    gb_o   = 1'b1;
    word_o = 9'h000;
    ra_n_o = 1'b1;
    rb_n_o = 1'b1;
    done_o = 1'b0;
  end

  // gates held 4 cycles around the edge since pins pass two flops
  task automatic pulse(input logic wr);
    repeat (4 + slow_i) @(negedge clk_i);
    push_o = wr;
    pop_o  = !wr;
    repeat (4) @(negedge clk_i);
    push_o = 1'b0;
    pop_o  = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask

  task automatic write(input logic ga_n, input logic gb, input logic [8:0] w);
    @(negedge clk_i);
    ga_n_o = ga_n;
    gb_o   = gb;
    word_o = w;
    pulse(1'b1);
    ga_n_o = 1'b1;
    word_o = ~w;
  endtask

  task automatic strap(input logic ld);
    @(negedge clk_i);
    gb_o = ld;
  endtask

  task automatic read(input logic rb_n, input logic ld);
    @(negedge clk_i);
    ra_n_o = 1'b0;
    rb_n_o = rb_n;
    gb_o   = ld;
    pulse(1'b0);
    done_o = 1'b1;
    @(negedge clk_i);
    done_o = 1'b0;
    ra_n_o = 1'b1;
    rb_n_o = ~rb_n_o;
  endtask
endmodule

// File: sim/testbench.sv
/*
  self-checking bench for the programmable-flag buffer.
  assumes the pin model paces every pin clock.
*/
`timescale 1ns/1ps
module testbench;
  localparam int DEPTH = 64;
  logic       clk_i;
  logic       rst_b_i;
  logic       init_n;
  logic       q_n;
  logic [1:0] slow;
  logic       push, ga_n, gb, pop, ra_n, rb_n, done;
  logic [8:0] word, out_word, last;
  logic       oe, full_n, af_n, empty_n, ae_n;
  logic [8:0] exp_q[$];
  logic [8:0] dq[$];
  int         err_count = 0;
  int         checks_done = 0;
  int         cycles = 0;
  integer     seed = 89562;

  sff_fifo_top #(.DEPTH(DEPTH)) sff_fifo_top_inst
  (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .init_n_i(init_n), .push_clock_i(push),
    .write_gate_a_n_i(ga_n), .write_gate_b_or_load_i(gb), .in_word_i(word),
    .pop_clock_i(pop), .read_gate_a_n_i(ra_n), .read_gate_b_n_i(rb_n),
    .q_drive_enable_n_i(q_n), .out_word_o(out_word), .out_word_oe_o(oe), .full_n_o(full_n),
    .almost_full_n_o(af_n), .empty_n_o(empty_n), .almost_empty_n_o(ae_n)
  );

  sff_pin_model pin
  (
    .clk_i(clk_i), .slow_i(slow), .push_o(push), .ga_n_o(ga_n), .gb_o(gb), .word_o(word),
    .pop_o(pop), .ra_n_o(ra_n), .rb_n_o(rb_n), .done_o(done)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [8:0] seen, input logic [8:0] e);
    checks_done++;
    if (seen !== e)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, e);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // result notes are taken off the queue as each read completes
  always @(posedge clk_i)
    if (done)
      chk(out_word, exp_q.pop_front());

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      err_count++;
      summarize();
    end
  end

  task automatic do_init(input logic ld);
    pin.strap(ld);
    init_n = 1'b0;
    repeat (8) @(negedge clk_i);
    init_n = 1'b1;
    repeat (4) @(negedge clk_i);
    last = 9'h000;
    chk(9'({full_n, af_n, empty_n, ae_n}), 9'h00c);
    chk(out_word, 9'h000);
  endtask

  task automatic rdo(input logic [8:0] e);
    exp_q.push_back(e);
    pin.read(1'b0, 1'b0);
  endtask

  task automatic rd(input logic b);
    if (!b && dq.size() > 0)
      last = dq.pop_front();
    exp_q.push_back(last);
    q_n = 1'($random(seed));
    slow = 2'($random(seed));
    pin.read(b, 1'b1);
    chk(9'(oe), 9'(!q_n));
  endtask

  // one write past depth must be refused
  task automatic fill(input int m);
    logic [8:0] w;
    for (int i = 1; i <= DEPTH + 1; i++)
    begin
      w = 9'($random(seed));
      pin.write(1'b0, 1'b1, w);
      if (i <= DEPTH)
        dq.push_back(w);
      chk(9'(af_n), 9'(i < DEPTH - m));
      chk(9'(full_n), 9'(i < DEPTH));
    end
  endtask

  task automatic drain(input int n);
    int   rem;
    logic b;
    rem = DEPTH;
    // empty_n moves on pop edges only, so a gated pop first makes the words visible
    rd(1'b1);
    chk(9'(empty_n), 9'h001);
    while (rem > 0)
    begin
      b = ($random(seed) & 3) == 0;
      rd(b);
      rem = rem - (b ? 0 : 1);
      if (!b && rem == DEPTH - 1)
      begin
        pin.write(1'b1, 1'b1, 9'h000);
        chk(9'(full_n), 9'h001);
      end
      if (rem <= n + 1)
        chk(9'(ae_n), 9'(rem > n));
      chk(9'(empty_n), 9'(rem != 0));
    end
    rd(1'b0);
  endtask

  initial
  begin
    rst_b_i = 1'b0;
    init_n = 1'b0;
    q_n = 1'b1;
    slow = 2'h0;
    last = 9'h000;
    repeat (12) @(negedge clk_i);
    rst_b_i = 1'b1;
    do_init(1'b0);
    rdo(9'h007);
    rdo(9'h000);
    rdo(9'h007);
    rdo(9'h000);
    $display("test offset defaults done");
    pin.write(1'b0, 1'b0, 9'h102);
    pin.write(1'b0, 1'b0, 9'h000);
    pin.write(1'b1, 1'b1, 9'h0aa);
    pin.write(1'b0, 1'b0, 9'h003);
    pin.write(1'b0, 1'b0, 9'h000);
    rdo(9'h002);
    rdo(9'h000);
    rdo(9'h003);
    rdo(9'h000);
    $display("test offset load done");
    fill(3);
    drain(2);
    $display("test load mode traffic done");
    do_init(1'b1);
    pin.write(1'b0, 1'b0, 9'h155);
    fill(7);
    drain(7);
    $display("test dual gate traffic done");
    summarize();
  end
endmodule
